// ==== design/ptc_pkg.sv ====
package ptc_pkg;

  // ****************************************
  // Register access codes
  // ****************************************
  localparam logic [7:0] CODE_CONFIG  = 8'h61;
  localparam logic [7:0] CODE_COMMAND = 8'h62;
  localparam logic [7:0] CODE_STATE   = 8'h63;
  localparam logic [7:0] CODE_READOUT = 8'h66;

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int CFG_W        = 22;
  localparam int CFG_TP_LSB   = 6;
  localparam int CFG_TP_W     = 16;
  localparam int CFG_LVL_LSB  = 4;
  localparam int CFG_HALT_BIT = 3;
  localparam int CFG_TAKEN    = 2;
  localparam int CFG_LOAD     = 1;
  localparam int CFG_RET      = 0;
  localparam logic [21:0] CFG_RESET = 22'h000000;

  localparam int CMD_W       = 4;
  localparam int CMD_CLEAR   = 3;
  localparam int CMD_START   = 2;
  localparam int CMD_STOP    = 1;
  localparam int CMD_SAMPLE  = 0;

  localparam int ST_STARTED  = 17;
  localparam int ST_OVF      = 16;
  localparam int ITEM_W      = 18;

  localparam logic [1:0] TAG_PC   = 2'h1;
  localparam logic [1:0] TAG_READ = 2'h2;

  // ****************************************
  // Compression levels
  // ****************************************
  typedef enum logic [1:0] {
    LVL_COMPLETE = 2'h0,
    LVL_FLOW     = 2'h1,
    LVL_RSVD     = 2'h2,
    LVL_FLOW_CC  = 2'h3
  } ptc_level_t;

  // ****************************************
  // Counts and buffer size
  // ****************************************
  localparam logic [15:0] LIMIT_COMPLETE = 16'h8000;
  localparam logic [15:0] LIMIT_FLOW_CC  = 16'h2000;
  localparam int          BUF_AW         = 9;
  localparam logic [9:0]  BUF_DEPTH      = 10'h200;

endpackage : ptc_pkg

// ==== design/ptc_top.sv ====
`timescale 1ns/10ps

module ptc_top
#(
  parameter bit EXTERNAL_TRACE = 1'b0
)
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  // Debug module register access
  input  wire logic                       acc_valid,
  input  wire logic                       acc_write,
  input  wire logic [7:0]                 acc_code,
  input  wire logic [ptc_pkg::CFG_W-1:0]  acc_wdata,
  output logic [ptc_pkg::ITEM_W-1:0]      acc_rdata,
  output logic                            acc_rvalid,
  // Processor execution events
  input  wire logic                       instr_done,
  input  wire logic                       branch_taken,
  input  wire logic                       return_taken,
  input  wire logic                       load_done,
  input  wire logic [0:31]                new_pc,
  input  wire logic [0:31]                load_value,
  input  wire logic [0:31]                machine_status,
  input  wire logic [4:0]                 dest_reg,
  input  wire logic                       dest_written,
  // Triggers
  input  wire logic [15:0]                break_hit,
  input  wire logic                       xtrig_start,
  input  wire logic                       xtrig_stop,
  // Processor control
  output logic                            debug_halt,
  output logic                            trace_running
);

  typedef struct packed {
    logic [ptc_pkg::CFG_W-1:0]  cfg;
    logic                       started;
    logic                       ovf;
    logic [15:0]                items;
    logic [15:0]                cyc;
    logic [ptc_pkg::ITEM_W-1:0] rdata;
    logic                       rvalid;
    logic                       halt;
  } ptc_state_t;

  ptc_state_t                 s_q;
  ptc_state_t                 s_d;
  ptc_pkg::ptc_level_t        level;
  logic                       cfg_wr;
  logic                       cmd_wr;
  logic                       rd_state;
  logic                       rd_out;
  logic                       pop;
  logic                       ovf_evt;
  logic                       counting;
  logic [15:0]                limit;
  logic [1:0]                 push_n;
  logic [ptc_pkg::ITEM_W-1:0] item_a;
  logic [ptc_pkg::ITEM_W-1:0] item_b;
  logic                       push_ok;
  logic [ptc_pkg::ITEM_W-1:0] head;
  logic [9:0]                 count;
  logic                       full;
  logic                       full_evt;

  // ****************************************
  // Access decode
  // ****************************************
  function automatic logic hit(input logic [7:0] code, input logic [7:0] want);
    hit = (code == want);
  endfunction : hit

  always_comb
  begin
    cfg_wr   = 1'b0;
    cmd_wr   = 1'b0;
    rd_state = 1'b0;
    rd_out   = 1'b0;
    // Writes to status or readout and reads of config or command fall through.
    if (acc_valid && acc_write && hit(acc_code, ptc_pkg::CODE_CONFIG))
    begin
      cfg_wr = 1'b1;
    end
    else if (acc_valid && acc_write && hit(acc_code, ptc_pkg::CODE_COMMAND))
    begin
      cmd_wr = 1'b1;
    end
    else if (acc_valid && !acc_write && hit(acc_code, ptc_pkg::CODE_STATE))
    begin
      rd_state = 1'b1;
    end
    else if (acc_valid && !acc_write && hit(acc_code, ptc_pkg::CODE_READOUT))
    begin
      rd_out = !EXTERNAL_TRACE;
    end
  end

  // The reserved level stores program-flow entities like level one.
  assign level = ptc_pkg::ptc_level_t'(s_q.cfg[ptc_pkg::CFG_LVL_LSB +: 2]);
  assign pop   = rd_out;

  // ****************************************
  // Cycle counting
  // ****************************************
  assign counting = s_q.started && ((level == ptc_pkg::LVL_COMPLETE) ||
                                    (level == ptc_pkg::LVL_FLOW_CC));
  assign limit    = (level == ptc_pkg::LVL_COMPLETE) ? ptc_pkg::LIMIT_COMPLETE
                                                     : ptc_pkg::LIMIT_FLOW_CC;
  // The counter saturates at the limit; each idle cycle spent there is an overflow.
  assign ovf_evt  = counting && !instr_done && (s_q.cyc == limit);

  // ****************************************
  // Item building
  // ****************************************
  always_comb
  begin
    push_n = 2'h0;
    item_a = '0;
    item_b = '0;
    // One entity per instruction; a taken branch outranks a return and a load.
    if (s_q.started && instr_done)
    begin
      if (level == ptc_pkg::LVL_COMPLETE)
      begin
        if (!EXTERNAL_TRACE)
        begin
          push_n = 2'h2;
          item_a = {s_q.cyc[14:0], machine_status[17:19]};
          item_b = {machine_status[20:31], dest_reg, dest_written};
        end
      end
      else if (branch_taken && s_q.cfg[ptc_pkg::CFG_TAKEN])
      begin
        push_n = 2'h2;
        item_a = {ptc_pkg::TAG_PC, new_pc[0:15]};
        item_b = {ptc_pkg::TAG_PC, new_pc[16:31]};
      end
      else if (return_taken && s_q.cfg[ptc_pkg::CFG_RET])
      begin
        push_n = 2'h2;
        item_a = {ptc_pkg::TAG_PC, new_pc[0:15]};
        item_b = {ptc_pkg::TAG_PC, new_pc[16:31]};
      end
      else if (load_done && s_q.cfg[ptc_pkg::CFG_LOAD])
      begin
        push_n = 2'h2;
        item_a = {ptc_pkg::TAG_READ, load_value[0:15]};
        item_b = {ptc_pkg::TAG_READ, load_value[16:31]};
      end
    end
  end

  // An entity that does not fit is dropped whole, so the reader never sees half of one.
  assign full_evt = s_q.started && (full || ((push_n != 2'h0) && !push_ok));

  // ****************************************
  // Control and status
  // ****************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = rd_state || rd_out || (acc_valid && !acc_write);
    // Read data stands for one cycle and returns to zero, so idle cycles read as zero.
    s_d.rdata  = '0;
    s_d.halt   = 1'b0;
    if (cfg_wr)
    begin
      s_d.cfg = acc_wdata;
    end
    if (counting)
    begin
      if (instr_done)
      begin
        s_d.cyc = 16'h0001;
      end
      else if (s_q.cyc != limit)
      begin
        s_d.cyc = s_q.cyc + 16'h0001;
      end
    end
    else
    begin
      s_d.cyc = 16'h0001;
    end
    if (|(break_hit & s_q.cfg[ptc_pkg::CFG_TP_LSB +: ptc_pkg::CFG_TP_W]) || xtrig_start)
    begin
      s_d.started = 1'b1;
    end
    if (xtrig_stop || full_evt)
    begin
      s_d.started = 1'b0;
    end
    // Command bits act in a fixed order: clear, start, stop, sample; stop beats start.
    if (cmd_wr && acc_wdata[ptc_pkg::CMD_CLEAR])
    begin
      s_d.started = 1'b0;
      s_d.ovf     = 1'b0;
      s_d.items   = 16'h0000;
    end
    if (cmd_wr && acc_wdata[ptc_pkg::CMD_START])
    begin
      s_d.started = 1'b1;
    end
    if (cmd_wr && acc_wdata[ptc_pkg::CMD_STOP])
    begin
      s_d.started = 1'b0;
    end
    if (cmd_wr && acc_wdata[ptc_pkg::CMD_SAMPLE])
    begin
      s_d.items = {6'h00, count};
    end
    // Overflow is applied after clear so that an overflow in the clear cycle is kept.
    if (ovf_evt)
    begin
      s_d.ovf = 1'b1;
    end
    if (s_q.cfg[ptc_pkg::CFG_HALT_BIT] && (ovf_evt || full_evt))
    begin
      s_d.halt = 1'b1;
    end
    if (rd_state)
    begin
      s_d.rdata = {s_q.started, s_q.ovf, s_q.items};
    end
    else if (rd_out)
    begin
      s_d.rdata = (count != 10'h000) ? head : '0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q     <= '0;
      s_q.cfg <= ptc_pkg::CFG_RESET;
      // The counter starts at one, the count of the instruction now executing.
      s_q.cyc <= 16'h0001;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Trace buffer
  // ****************************************
  // The clear command empties the buffer in the same cycle as it clears the status.
  ptc_trace_buf u_buf
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .push_n  (push_n),
    .item_a  (item_a),
    .item_b  (item_b),
    .push_ok (push_ok),
    .pop     (pop),
    .clear   (cmd_wr && acc_wdata[ptc_pkg::CMD_CLEAR]),
    .head    (head),
    .count   (count),
    .full    (full)
  );

  assign acc_rdata     = s_q.rdata;
  assign acc_rvalid    = s_q.rvalid;
  assign debug_halt    = s_q.halt;
  assign trace_running = s_q.started;

endmodule : ptc_top

// ==== design/ptc_trace_buf.sv ====
`timescale 1ns/10ps

module ptc_trace_buf
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  // Write side
  input  wire logic [1:0]                 push_n,
  input  wire logic [ptc_pkg::ITEM_W-1:0] item_a,
  input  wire logic [ptc_pkg::ITEM_W-1:0] item_b,
  output logic                            push_ok,
  // Read side and control
  input  wire logic                       pop,
  input  wire logic                       clear,
  output logic [ptc_pkg::ITEM_W-1:0]      head,
  output logic [9:0]                      count,
  output logic                            full
);

  typedef struct packed {
    logic [511:0][ptc_pkg::ITEM_W-1:0] mem;
    logic [ptc_pkg::BUF_AW-1:0]        rp;
    logic [ptc_pkg::BUF_AW-1:0]        wp;
    logic [9:0]                        cnt;
  } ptc_buf_t;

  ptc_buf_t s_q;
  ptc_buf_t s_d;
  logic     do_pop;

  // ****************************************
  // Storage and pointers
  // ****************************************
  always_comb
  begin
    s_d     = s_q;
    do_pop  = pop && (s_q.cnt != 10'h000);
    push_ok = ((s_q.cnt + {8'h00, push_n}) <= ptc_pkg::BUF_DEPTH);
    if (clear)
    begin
      s_d.rp  = '0;
      s_d.wp  = '0;
      s_d.cnt = 10'h000;
    end
    else
    begin
      if (push_ok && (push_n != 2'h0))
      begin
        s_d.mem[s_q.wp] = item_a;
        if (push_n == 2'h2)
        begin
          s_d.mem[s_q.wp + 9'h001] = item_b;
        end
        s_d.wp = s_q.wp + {7'h00, push_n};
      end
      if (do_pop)
      begin
        s_d.rp = s_q.rp + 9'h001;
      end
      s_d.cnt = s_q.cnt + (push_ok ? {8'h00, push_n} : 10'h000) - {9'h000, do_pop};
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign head  = s_q.mem[s_q.rp];
  assign count = s_q.cnt;
  assign full  = (s_q.cnt == ptc_pkg::BUF_DEPTH);

endmodule : ptc_trace_buf

// ==== tb/program_trace_control_test.sv ====
`timescale 1ns/10ps

module program_trace_control_test;
  logic        clk_sys, sys_rst, acc_valid, acc_write, acc_rvalid, debug_halt, trace_running;
  logic        instr_done, branch_taken, return_taken, load_done, dest_written;
  logic        xtrig_start, xtrig_stop;
  logic [7:0]  acc_code;
  logic [21:0] acc_wdata;
  logic [17:0] acc_rdata;
  logic [0:31] new_pc, load_value, machine_status;
  logic [4:0]  dest_reg;
  logic [15:0] break_hit;
  int          n_mismatch = 0;
  int          n_compared = 0;

  ptc_top uut (.clk_sys, .sys_rst, .acc_valid, .acc_write, .acc_code, .acc_wdata, .acc_rdata,
    .acc_rvalid, .instr_done, .branch_taken, .return_taken, .load_done, .new_pc, .load_value,
    .machine_status, .dest_reg, .dest_written, .break_hit, .xtrig_start, .xtrig_stop,
    .debug_halt, .trace_running);
  ptc_dbg_model dbg (.clk_sys, .acc_valid, .acc_write, .acc_code, .acc_wdata, .acc_rdata,
    .acc_rvalid);

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [7:0] code, output logic [17:0] v);
    logic ok;
    dbg.access(1'b0, code, 22'h000000, v, ok);
    chk("read answer", 18'h00001, {17'h00000, ok});
  endtask : rd

  task automatic wr(input logic [7:0] code, input logic [21:0] d);
    logic [17:0] v;
    logic        ok;
    dbg.access(1'b1, code, d, v, ok);
    chk("write quiet", 18'h00001, {17'h00000, ok});
  endtask : wr

  task automatic instr(input logic b, input logic r, input logic l);
    @(negedge clk_sys);
    instr_done = 1'b1;
    branch_taken = b;
    return_taken = r;
    load_done = l;
    @(negedge clk_sys);
    instr_done = 1'b0;
  endtask : instr

  task automatic t_regs();
    logic [17:0] v;
    rd(ptc_pkg::CODE_STATE, v);
    chk("state reset", 18'h00000, v);
    rd(ptc_pkg::CODE_READOUT, v);
    chk("readout reset", 18'h00000, v);
    wr(ptc_pkg::CODE_STATE, 22'h3fffff);
    wr(ptc_pkg::CODE_READOUT, 22'h3fffff);
    wr(ptc_pkg::CODE_COMMAND, 22'h000000);
    rd(ptc_pkg::CODE_CONFIG, v);
    rd(ptc_pkg::CODE_COMMAND, v);
    rd(ptc_pkg::CODE_STATE, v);
    chk("state kept", 18'h00000, v);
  endtask : t_regs

  task automatic t_flow();
    logic [17:0] v;
    logic [1:0]  tag;
    for (int k = 0; k < 3; k++)
    begin
      new_pc = 32'h1234abcd + k;
      load_value = 32'h5a5a0f0f + k;
      tag = (k == 1) ? ptc_pkg::TAG_READ : ptc_pkg::TAG_PC;
      wr(ptc_pkg::CODE_CONFIG, {16'h0000, 2'h1, 4'(1 << k)});
      wr(ptc_pkg::CODE_COMMAND, 22'h00000c);
      instr(k == 2, k == 0, k == 1);
      wr(ptc_pkg::CODE_COMMAND, 22'h000003);
      rd(ptc_pkg::CODE_STATE, v);
      chk("flow count", 18'h00002, v);
      rd(ptc_pkg::CODE_READOUT, v);
      chk("flow high", {tag, (k == 1) ? load_value[0:15] : new_pc[0:15]}, v);
      rd(ptc_pkg::CODE_READOUT, v);
      chk("flow low", {tag, (k == 1) ? load_value[16:31] : new_pc[16:31]}, v);
    end
  endtask : t_flow

  task automatic t_complete();
    logic [17:0] v;
    machine_status = 32'h0002_5a5b;
    dest_reg = 5'h13;
    dest_written = 1'b1;
    wr(ptc_pkg::CODE_CONFIG, 22'h000000);
    wr(ptc_pkg::CODE_COMMAND, 22'h00000c);
    instr(1'b0, 1'b0, 1'b0);
    wr(ptc_pkg::CODE_COMMAND, 22'h000002);
    rd(ptc_pkg::CODE_READOUT, v);
    chk("complete first", {15'h0002, machine_status[17:19]}, v);
    rd(ptc_pkg::CODE_READOUT, v);
    chk("complete second", {machine_status[20:31], 5'h13, 1'b1}, v);
  endtask : t_complete

  task automatic pulse(input logic [15:0] b, input logic s, input logic p);
    @(negedge clk_sys);
    break_hit = b;
    xtrig_start = s;
    xtrig_stop = p;
    @(negedge clk_sys);
    break_hit = 16'h0000;
    xtrig_start = 1'b0;
    xtrig_stop = 1'b0;
  endtask : pulse

  task automatic t_trig();
    wr(ptc_pkg::CODE_CONFIG, {16'h0008, 2'h1, 4'h0});
    wr(ptc_pkg::CODE_COMMAND, 22'h000008);
    pulse(16'h0001, 1'b0, 1'b0);
    chk("plain break", 18'h00000, {17'h00000, trace_running});
    pulse(16'h0008, 1'b0, 1'b0);
    chk("tracepoint start", 18'h00001, {17'h00000, trace_running});
    pulse(16'h0000, 1'b0, 1'b1);
    chk("cross stop", 18'h00000, {17'h00000, trace_running});
    pulse(16'h0000, 1'b1, 1'b0);
    chk("cross start", 18'h00001, {17'h00000, trace_running});
    wr(ptc_pkg::CODE_COMMAND, 22'h000002);
    chk("stop command", 18'h00000, {17'h00000, trace_running});
  endtask : t_trig

  task automatic t_full();
    logic [17:0] v;
    wr(ptc_pkg::CODE_CONFIG, {16'h0000, 2'h1, 4'hc});
    wr(ptc_pkg::CODE_COMMAND, 22'h00000c);
    for (int k = 0; k < 256; k++)
    begin
      instr(1'b1, 1'b0, 1'b0);
    end
    @(negedge clk_sys);
    chk("full halt", 18'h00001, {17'h00000, debug_halt});
    chk("full stops", 18'h00000, {17'h00000, trace_running});
    instr(1'b1, 1'b0, 1'b0);
    wr(ptc_pkg::CODE_COMMAND, 22'h000001);
    rd(ptc_pkg::CODE_STATE, v);
    chk("full count", 18'h00200, v);
    rd(ptc_pkg::CODE_READOUT, v);
    chk("full head", {ptc_pkg::TAG_PC, new_pc[0:15]}, v);
    wr(ptc_pkg::CODE_COMMAND, 22'h000008);
  endtask : t_full

  task automatic t_ovf();
    logic [17:0] v;
    int          n;
    int          lim;
    for (int j = 0; j < 2; j++)
    begin
      n = 0;
      lim = (j == 0) ? 8192 : 32768;
      wr(ptc_pkg::CODE_CONFIG, {16'h0000, (j == 0) ? 2'h3 : 2'h0, 4'h8});
      wr(ptc_pkg::CODE_COMMAND, 22'h000004);
      while (debug_halt !== 1'b1 && n < lim + 100)
      begin
        @(negedge clk_sys);
        n++;
      end
      if (n >= lim + 100)
      begin
        n_mismatch++;
        test_done();
      end
      chk("overflow wait", 18'h00001, {17'h00000, n >= lim - 12 && n <= lim + 8});
      rd(ptc_pkg::CODE_STATE, v);
      chk("overflow flag", 18'h00003, {16'h0000, v[17:16]});
      wr(ptc_pkg::CODE_COMMAND, 22'h000002);
      rd(ptc_pkg::CODE_STATE, v);
      chk("overflow kept", 18'h00001, {16'h0000, v[17:16]});
      wr(ptc_pkg::CODE_COMMAND, 22'h000009);
      rd(ptc_pkg::CODE_STATE, v);
      chk("cleared", 18'h00000, v);
    end
  endtask : t_ovf

  initial
  begin
    sys_rst = 1'b1;
    {instr_done, branch_taken, return_taken, load_done, dest_written} = 5'h00;
    {xtrig_start, xtrig_stop} = 2'h0;
    {new_pc, load_value, machine_status} = 96'h0;
    dest_reg = 5'h00;
    break_hit = 16'h0000;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    t_regs();
    t_flow();
    t_complete();
    t_trig();
    t_full();
    t_ovf();
    test_done();
  end
endmodule : program_trace_control_test

bind ptc_top ptc_checker chk_i (.clk_sys, .sys_rst, .acc_valid, .acc_write, .acc_code,
  .acc_wdata, .acc_rdata, .acc_rvalid, .debug_halt, .trace_running);

// ==== tb/ptc_checker.sv ====
`timescale 1ns/10ps

module ptc_checker
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Register access
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [7:0]  acc_code,
  input wire logic [21:0] acc_wdata,
  input wire logic [17:0] acc_rdata,
  input wire logic        acc_rvalid,
  // Processor control
  input wire logic        debug_halt,
  input wire logic        trace_running
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  logic rd_req;
  logic cmd_w;
  assign rd_req = acc_valid && !acc_write;
  assign cmd_w  = acc_valid && acc_write && acc_code == ptc_pkg::CODE_COMMAND;

  chk_read_answer:
    assert property (rd_req |=> acc_rvalid) else $error("read not answered");
  chk_no_stray:
    assert property (!rd_req |=> !acc_rvalid) else $error("answer without read");
  chk_wo_read_zero:
    assert property (rd_req && (acc_code == ptc_pkg::CODE_CONFIG
      || acc_code == ptc_pkg::CODE_COMMAND) |=> acc_rdata == 18'h00000)
    else $error("write-only read not zero");
  chk_idle_rdata:
    assert property (!acc_rvalid |-> acc_rdata == 18'h00000) else $error("stray read data");
  chk_start_cmd:
    assert property (cmd_w && acc_wdata[ptc_pkg::CMD_START] && !acc_wdata[ptc_pkg::CMD_STOP]
      |=> trace_running) else $error("start ignored");
  chk_stop_cmd:
    assert property (cmd_w && acc_wdata[ptc_pkg::CMD_STOP] |=> !trace_running)
    else $error("stop ignored");
  chk_clear_stops:
    assert property (cmd_w && acc_wdata[ptc_pkg::CMD_CLEAR] && !acc_wdata[ptc_pkg::CMD_START]
      ##1 1'b1 |-> !trace_running) else $error("clear left trace on");
  chk_state_started:
    assert property (rd_req && acc_code == ptc_pkg::CODE_STATE
      |=> acc_rdata[ptc_pkg::ST_STARTED] == $past(trace_running)) else $error("started bit");

  cover property ($rose(trace_running));
  cover property (debug_halt);
  cover property (rd_req && acc_code == ptc_pkg::CODE_READOUT);
endmodule : ptc_checker

// ==== tb/ptc_dbg_model.sv ====
`timescale 1ns/10ps

module ptc_dbg_model
(
  // Clock
  input wire logic         clk_sys,
  // Register access
  output logic             acc_valid,
  output logic             acc_write,
  output logic [7:0]       acc_code,
  output logic [21:0]      acc_wdata,
  input  wire logic [17:0] acc_rdata,
  input  wire logic        acc_rvalid
);
  initial
  begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_code  = 8'h00;
    acc_wdata = 22'h000000;
  end

  // One access of one cycle; idle code and data lines show the inverse of their last value.
  task automatic access(input logic wr, input logic [7:0] code, input logic [21:0] wd,
                        output logic [17:0] rd, output logic ok);
    @(negedge clk_sys);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_code  = code;
    acc_wdata = wd;
    @(negedge clk_sys);
    rd = acc_rdata;
    ok = (acc_rvalid === !wr);
    acc_valid = 1'b0;
    acc_code  = ~acc_code;
    acc_wdata = ~acc_wdata;
  endtask : access
endmodule : ptc_dbg_model
